// ---- logic/fdc_host_port.sv ----
// Host end: Wishbone-controlled agent that performs controller I/O accesses
`timescale 1ns/1ps
`default_nettype none
module fdc_host_port (
    input  wire logic        MCLK_I,
    input  wire logic        RESET_N_I,
    input  wire logic        CE_I,
    input  wire logic        CYC_I,
    input  wire logic        STB_I,
    input  wire logic        WE_I,
    input  wire logic [3:0]  ADR_I,
    input  wire logic [3:0]  SEL_I,
    input  wire logic [31:0] DAT_I,
    output logic [31:0]      DAT_O,
    output logic             ACK_O,
    output logic             BUSY_O,
    fdc_io_if.host           IO
);
    import fdc_pkg::*;

    typedef enum logic [2:0] {H_IDLE, H_POLL, H_POLL_WAIT, H_ACCESS, H_ACC_WAIT} hstate_t;

    hstate_t     state_r;
    logic [2:0]  addr_r;
    logic        we_r;
    logic [7:0]  wdata_r;
    logic [7:0]  result_r;
    logic        refused_r;
    logic        ack_r;
    logic [31:0] dat_r;
    logic        bus_req;
    logic        start;
    logic        poll_ok;

    assign bus_req = CE_I && CYC_I && STB_I && !ack_r;
    assign start   = bus_req && WE_I && (ADR_I == HOST_OFS_REQ) && SEL_I[0]
                     && (state_r == H_IDLE);
    // Byte may move only with request set and direction matching
    assign poll_ok = IO.rdata[BIT_REQUEST] && (IO.rdata[BIT_DIRECTION] == !we_r);

    ////////////////////////////////////////////////////////////////////////////
    // Wishbone slave: ack one cycle after the strobe, dropped the next
    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else if (CE_I) begin
            ack_r <= CYC_I && STB_I && !ack_r;
            if (bus_req && !WE_I && (ADR_I == HOST_OFS_STAT)) begin
                dat_r <= {16'h0000, result_r, 6'h00, refused_r, state_r != H_IDLE};
            end else if (bus_req) begin
                dat_r <= 32'h0000_0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Access sequencer
    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            state_r <= H_IDLE;
        end else if (CE_I) begin
            case (state_r)
                H_IDLE: begin
                    if (start) begin
                        state_r <= (DAT_I[2:0] == OFS_DATA) ? H_POLL : H_ACCESS;
                    end
                end
                H_POLL:      state_r <= H_POLL_WAIT;
                H_POLL_WAIT: state_r <= poll_ok ? H_ACCESS : H_IDLE;
                H_ACCESS:    state_r <= we_r ? H_IDLE : H_ACC_WAIT;
                default:     state_r <= H_IDLE;
            endcase
        end
    end

    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            addr_r  <= 3'h0;
            we_r    <= 1'b0;
            wdata_r <= 8'h00;
        end else if (start) begin
            addr_r  <= DAT_I[2:0];
            we_r    <= DAT_I[HREQ_WE_BIT];
            wdata_r <= DAT_I[HREQ_DATA_LSB +: 8];
            if (DAT_I[2:0] == OFS_STATUS) begin
                wdata_r[BIT_RESERVED] <= 1'b0;
            end
        end
    end

    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            refused_r <= 1'b0;
            result_r  <= 8'h00;
        end else if (CE_I) begin
            if (start) begin
                refused_r <= 1'b0;
            end else if (state_r == H_POLL_WAIT) begin
                refused_r <= !poll_ok;
                result_r  <= IO.rdata;
            end else if (state_r == H_ACC_WAIT) begin
                result_r  <= IO.rdata;
            end
        end
    end

    assign IO.addr  = (state_r == H_POLL) ? OFS_STATUS : addr_r;
    assign IO.rd    = CE_I && ((state_r == H_POLL) || ((state_r == H_ACCESS) && !we_r));
    assign IO.wr    = CE_I && (state_r == H_ACCESS) && we_r;
    assign IO.wdata = wdata_r;
    assign ACK_O    = ack_r;
    assign DAT_O    = dat_r;
    assign BUSY_O   = (state_r != H_IDLE);

endmodule : fdc_host_port
`default_nettype wire

// ---- logic/fdc_io_if.sv ----
// Controller I/O port between host end and device end
`timescale 1ns/1ps
`default_nettype none
interface fdc_io_if;
    logic [2:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport dev  (input addr, input wr, input rd, input wdata, output rdata);
    modport host (output addr, output wr, output rd, output wdata, input rdata);
endinterface : fdc_io_if
`default_nettype wire

// ---- logic/fdc_pkg.sv ----
// Shared constants, types and decode functions for the floppy status/rate registers
package fdc_pkg;

    // Controller I/O offsets from base
    localparam logic [2:0]  OFS_TAPE      = 3'h3;
    localparam logic [2:0]  OFS_STATUS    = 3'h4;
    localparam logic [2:0]  OFS_DATA      = 3'h5;
    localparam logic [2:0]  OFS_RATE_CTRL = 3'h7;

    // Rate/precomp register fields and reset
    localparam logic [7:0]  RATE_REG_RST  = 8'h02;
    localparam int          BIT_SW_RESET  = 7;
    localparam int          BIT_LOW_POWER = 6;
    localparam int          BIT_RESERVED  = 5;
    localparam int          PRECOMP_LSB   = 2;
    localparam int          PRECOMP_MSB   = 4;
    localparam logic [2:0]  PRECOMP_RST   = 3'h0;
    localparam logic [1:0]  RATE_SEL_RST  = 2'h2;

    // Status register fields
    localparam int          BIT_REQUEST   = 7;
    localparam int          BIT_DIRECTION = 6;

    // Write precompensation delays in femtoseconds
    localparam logic [17:0] DLY_0_PS      = 18'h00000;
    localparam logic [17:0] DLY_41_PS     = 18'h0A2C6;
    localparam logic [17:0] DLY_83_PS     = 18'h1458C;
    localparam logic [17:0] DLY_125_PS    = 18'h1E848;
    localparam logic [17:0] DLY_166_PS    = 18'h28B0E;
    localparam logic [17:0] DLY_208_PS    = 18'h32DCA;
    localparam logic [17:0] DLY_250_PS    = 18'h3D090;

    // Host controller register map (Wishbone byte addresses)
    localparam logic [3:0]  HOST_OFS_REQ  = 4'h0;
    localparam logic [3:0]  HOST_OFS_STAT = 4'h4;
    localparam int          HREQ_WE_BIT   = 8;
    localparam int          HREQ_DATA_LSB = 16;

    // MFM rates; FM is half of each
    typedef enum logic [2:0] {RATE_250K, RATE_300K, RATE_500K, RATE_1M, RATE_2M} rate_t;

    function automatic rate_t rate_decode(input logic [1:0] drt, input logic [1:0] sel);
        rate_t r;
        r = RATE_250K;
        case (sel)
            2'h3: r = RATE_1M;
            2'h0: r = RATE_500K;
            2'h2: r = RATE_250K;
            default: begin
                if (drt == 2'h1) r = RATE_500K;
                else if (drt == 2'h2) r = RATE_2M;
                else r = RATE_300K;
            end
        endcase
        return r;
    endfunction : rate_decode

    function automatic logic [17:0] precomp_delay(input logic [2:0] code, input rate_t r);
        logic [17:0] d;
        d = DLY_0_PS;
        case (code)
            3'h7: d = DLY_0_PS;
            3'h1: d = DLY_41_PS;
            3'h2: d = DLY_83_PS;
            3'h3: d = DLY_125_PS;
            3'h4: d = DLY_166_PS;
            3'h5: d = DLY_208_PS;
            3'h6: d = DLY_250_PS;
            default: d = (r == RATE_1M) ? DLY_41_PS : DLY_125_PS;
        endcase
        return d;
    endfunction : precomp_delay

endpackage : fdc_pkg

// ---- logic/fdc_status_rate.sv ----
// Device end: status, tape info and rate/precomp registers of the floppy controller
`timescale 1ns/1ps
`default_nettype none
module fdc_status_rate (
    input  wire logic                MCLK_I,
    input  wire logic                RESET_N_I,
    input  wire logic                CE_I,
    fdc_io_if.dev                    IO,
    input  wire logic                ENH_MODE2_I,
    input  wire logic [1:0]          LAST_DRIVE_I,
    input  wire logic [7:0]          DRIVE_TYPE_CFG_I,
    input  wire logic [1:0]          BOOT_DRIVE_CFG_I,
    input  wire logic [1:0]          DRIVE_RATE_CFG_I,
    input  wire logic                IDENT_I,
    input  wire logic                CTRL_RESET_I,
    input  wire logic [3:0]          SEEK_BUSY_I,
    input  wire logic                CMD_BUSY_I,
    input  wire logic                EXEC_PHASE_I,
    input  wire logic                NON_DMA_I,
    input  wire logic                REQUEST_I,
    input  wire logic                DIR_READ_I,
    input  wire logic [7:0]          TRACK_I,
    input  wire logic [7:0]          PRECOMP_TRACK_I,
    input  wire logic [7:0]          FIFO_RDATA_I,
    output logic                     FIFO_WR_O,
    output logic                     FIFO_RD_O,
    output logic [7:0]               FIFO_WDATA_O,
    output fdc_pkg::rate_t           DATA_RATE_O,
    output logic [1:0]               RATE_SEL_O,
    output logic [17:0]              PRECOMP_PS_O,
    output logic                     DENSITY_SELECT_O,
    output logic                     LOW_POWER_O,
    output logic                     SOFT_RESET_O
);
    import fdc_pkg::*;

    logic [1:0]  rate_sel_r;
    logic [2:0]  precomp_r;
    logic [1:0]  tape_sel_r;
    logic        low_power_r;
    logic        soft_reset_r;
    logic        density_r;
    logic [7:0]  rdata_r;
    logic [7:0]  fifo_wdata_r;
    logic [7:0]  rdata_nxt;
    logic [7:0]  status_now;
    logic [7:0]  tape_now;
    logic [1:0]  drive_type;
    logic [17:0] precomp_nxt;
    rate_t       rate_now;

    logic wr_rate, wr_ctrl, wr_tape, acc_status, acc_data;

    assign wr_rate    = CE_I && IO.wr && (IO.addr == OFS_STATUS);
    assign wr_ctrl    = CE_I && IO.wr && (IO.addr == OFS_RATE_CTRL);
    assign wr_tape    = CE_I && IO.wr && (IO.addr == OFS_TAPE);
    assign acc_status = CE_I && IO.rd && (IO.addr == OFS_STATUS);
    assign acc_data   = CE_I && (IO.rd || IO.wr) && (IO.addr == OFS_DATA);

    ////////////////////////////////////////////////////////////////////////////
    // Status register: live inputs, no latching, so a poll right after a
    // data byte already sees the sequencer's updated request flag
    always_comb begin
        status_now               = 8'h00;
        status_now[3:0]          = SEEK_BUSY_I;
        status_now[4]            = CMD_BUSY_I;
        status_now[5]            = NON_DMA_I && EXEC_PHASE_I;
        status_now[BIT_DIRECTION] = REQUEST_I && DIR_READ_I;
        status_now[BIT_REQUEST]  = REQUEST_I;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Tape register read view
    always_comb begin
        case (LAST_DRIVE_I)
            2'h0: drive_type = DRIVE_TYPE_CFG_I[1:0];
            2'h1: drive_type = DRIVE_TYPE_CFG_I[3:2];
            2'h2: drive_type = DRIVE_TYPE_CFG_I[5:4];
            default: drive_type = DRIVE_TYPE_CFG_I[7:6];
        endcase
        tape_now      = 8'h00;
        tape_now[1:0] = tape_sel_r;
        if (ENH_MODE2_I) begin
            tape_now[5:4] = drive_type;
            tape_now[3:2] = BOOT_DRIVE_CFG_I;
        end
    end

    always_comb begin
        if (IO.addr == OFS_STATUS) begin
            rdata_nxt = status_now;
        end else if (IO.addr == OFS_TAPE) begin
            rdata_nxt = tape_now;
        end else if (IO.addr == OFS_DATA) begin
            rdata_nxt = FIFO_RDATA_I;
        end else begin
            rdata_nxt = 8'h00;
        end
    end

    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            rdata_r <= 8'h00;
        end else if (CE_I && IO.rd) begin
            rdata_r <= rdata_nxt;
        end
    end

    // Tape select is kept across soft reset
    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            tape_sel_r <= 2'h0;
        end else if (wr_tape) begin
            tape_sel_r <= IO.wdata[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Rate and precomp storage; only hardware reset touches it
    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            rate_sel_r <= RATE_SEL_RST;
            precomp_r  <= PRECOMP_RST;
        end else if (wr_rate) begin
            rate_sel_r <= IO.wdata[1:0];
            precomp_r  <= IO.wdata[PRECOMP_MSB:PRECOMP_LSB];
        end else if (wr_ctrl) begin
            rate_sel_r <= IO.wdata[1:0];
        end
    end

    // Self-clearing: the bit is never stored, only pulsed out
    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            soft_reset_r <= 1'b0;
        end else if (CE_I) begin
            soft_reset_r <= wr_rate && IO.wdata[BIT_SW_RESET];
        end
    end

    // A new low-power write in the same cycle as an exit event wins
    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            low_power_r <= 1'b0;
        end else if (wr_rate && IO.wdata[BIT_LOW_POWER] && !IO.wdata[BIT_SW_RESET]) begin
            low_power_r <= 1'b1;
        end else if (CE_I && (acc_status || acc_data || soft_reset_r || CTRL_RESET_I)) begin
            low_power_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Drive-side outputs
    assign rate_now    = rate_decode(DRIVE_RATE_CFG_I, rate_sel_r);
    assign precomp_nxt = (TRACK_I >= PRECOMP_TRACK_I)
                       ? precomp_delay(precomp_r, rate_now)
                       : DLY_0_PS;

    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            DATA_RATE_O  <= RATE_250K;
            RATE_SEL_O   <= RATE_SEL_RST;
            PRECOMP_PS_O <= DLY_0_PS;
        end else if (CE_I) begin
            DATA_RATE_O  <= rate_now;
            RATE_SEL_O   <= rate_sel_r;
            PRECOMP_PS_O <= precomp_nxt;
        end
    end

    // High for select 3 (1M) and select 0 (500K) with identity high, inverted with it low
    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            density_r <= 1'b1;
        end else if (CE_I) begin
            density_r <= ((rate_sel_r == 2'h3) || (rate_sel_r == 2'h0)) == IDENT_I;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Data register pass-through to the command sequencer
    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            fifo_wdata_r <= 8'h00;
        end else if (CE_I && IO.wr && (IO.addr == OFS_DATA)) begin
            fifo_wdata_r <= IO.wdata;
        end
    end

    assign FIFO_WR_O        = CE_I && IO.wr && (IO.addr == OFS_DATA);
    assign FIFO_RD_O        = CE_I && IO.rd && (IO.addr == OFS_DATA);
    assign FIFO_WDATA_O     = fifo_wdata_r;
    assign IO.rdata         = rdata_r;
    assign DENSITY_SELECT_O = density_r;
    assign LOW_POWER_O      = low_power_r;
    assign SOFT_RESET_O     = soft_reset_r;

endmodule : fdc_status_rate
`default_nettype wire

// ---- verif/fdc_status_rate_asserts.sv ----
// Concurrent checks on the controller I/O link and device outputs
`timescale 1ns/1ps
`default_nettype none
module fdc_status_rate_asserts (
    input wire logic       MCLK_I,
    input wire logic       RESET_N_I,
    input wire logic       CE_I,
    input wire logic [2:0] addr,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic [3:0] SEEK_BUSY_I,
    input wire logic       CMD_BUSY_I,
    input wire logic       EXEC_PHASE_I,
    input wire logic       NON_DMA_I,
    input wire logic       REQUEST_I,
    input wire logic       DIR_READ_I,
    input wire logic       CTRL_RESET_I,
    input wire logic       FIFO_WR_O,
    input wire logic       FIFO_RD_O,
    input wire logic [1:0] RATE_SEL_O,
    input wire logic       LOW_POWER_O,
    input wire logic       SOFT_RESET_O
);
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RESET_N_I);
    ////////////////////////////////////////////////////////////////////////////////
    // Last select written through either rate location
    logic [1:0] sel_r;
    wire logic [7:0] stat_w = {REQUEST_I, REQUEST_I & DIR_READ_I, NON_DMA_I & EXEC_PHASE_I,
                               CMD_BUSY_I, SEEK_BUSY_I};
    wire logic rate_wr = CE_I && wr && (addr == 3'h4 || addr == 3'h7);
    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) sel_r <= 2'h2;
        else if (rate_wr) sel_r <= wdata[1:0];
    end
    sequence pulse_s;
        SOFT_RESET_O ##1 !SOFT_RESET_O;
    endsequence
    sequence lp_write_s;
        CE_I && wr && addr == 3'h4 && wdata[6] && !wdata[7];
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    sw_reset_pulse_a: assert property (CE_I && wr && addr == 3'h4 && wdata[7] |=> pulse_s)
        else $error("soft reset pulse wrong");
    rate_last_wr_a: assert property (rate_wr ##1 !wr |=> RATE_SEL_O == sel_r)
        else $error("rate select not last write");
    low_power_set_a: assert property (lp_write_s |-> ##[1:2] LOW_POWER_O)
        else $error("low power not entered");
    low_power_exit_a: assert property (LOW_POWER_O && rd && (addr == 3'h4 || addr == 3'h5)
        |-> ##[1:2] !LOW_POWER_O)
        else $error("low power kept after access");
    soft_exit_a: assert property (CE_I && LOW_POWER_O && CTRL_RESET_I |-> ##[1:2] !LOW_POWER_O)
        else $error("low power kept after soft reset");
    data_gate_a: assert property ((FIFO_WR_O || FIFO_RD_O) |-> rdata[7] && (rdata[6] == FIFO_RD_O))
        else $error("data access without matching request");
    status_read_a: assert property (CE_I && rd && addr == 3'h4 |=> rdata == $past(stat_w))
        else $error("status byte wrong");
    status_quiet_a: assert property (CE_I && rd && addr == 3'h4 |=> $stable(RATE_SEL_O))
        else $error("status read disturbed rate");
    fifo_strobe_a: assert property (CE_I && addr == 3'h5 |-> FIFO_WR_O == wr && FIFO_RD_O == rd)
        else $error("data strobe mismatch");
endmodule : fdc_status_rate_asserts
`default_nettype wire

// ---- verif/floppy_status_rate_regs_test.sv ----
// Testbench joining host port and device through the I/O interface
`timescale 1ns/1ps
`default_nettype none
module floppy_status_rate_regs_test;
    import fdc_pkg::*;
    logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, enh = 0, ident = 1, ctrl_rst = 0;
    logic cmd = 0, exec = 0, nondma = 0, req = 0, dir = 0, ce = 1;
    logic [3:0] adr = 4'h0, seek = 4'h0;
    logic [31:0] dat_w = 32'h0, dat_r;
    logic [7:0] tcfg = 8'h00, trk = 8'h0A, ptrk = 8'h00, fifo_rd = 8'h00, fifo_wdata;
    logic [1:0] last = 2'h0, boot = 2'h0, drt = 2'h0, rate_sel;
    logic ack, busy, dens, lp, sres, fwr, frd;
    logic [17:0] pre_ps;
    rate_t rate;
    int n_fail = 0, num_checks = 0;
    localparam logic [17:0] DL [8] = '{DLY_125_PS, DLY_41_PS, DLY_83_PS, DLY_125_PS,
                                       DLY_166_PS, DLY_208_PS, DLY_250_PS, DLY_0_PS};
    always #10 clk = ~clk;
    fdc_io_if io_bus ();
    fdc_host_port fdc_host_port_inst (.MCLK_I(clk), .RESET_N_I(rst_n), .CE_I(ce), .CYC_I(cyc),
        .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(4'hF), .DAT_I(dat_w), .DAT_O(dat_r),
        .ACK_O(ack), .BUSY_O(busy), .IO(io_bus));
    fdc_status_rate fdc_status_rate_inst (.MCLK_I(clk), .RESET_N_I(rst_n), .CE_I(ce),
        .IO(io_bus), .ENH_MODE2_I(enh), .LAST_DRIVE_I(last), .DRIVE_TYPE_CFG_I(tcfg),
        .BOOT_DRIVE_CFG_I(boot), .DRIVE_RATE_CFG_I(drt), .IDENT_I(ident),
        .CTRL_RESET_I(ctrl_rst), .SEEK_BUSY_I(seek), .CMD_BUSY_I(cmd), .EXEC_PHASE_I(exec),
        .NON_DMA_I(nondma), .REQUEST_I(req), .DIR_READ_I(dir), .TRACK_I(trk),
        .PRECOMP_TRACK_I(ptrk), .FIFO_RDATA_I(fifo_rd), .FIFO_WR_O(fwr), .FIFO_RD_O(frd),
        .FIFO_WDATA_O(fifo_wdata), .DATA_RATE_O(rate), .RATE_SEL_O(rate_sel),
        .PRECOMP_PS_O(pre_ps), .DENSITY_SELECT_O(dens), .LOW_POWER_O(lp), .SOFT_RESET_O(sres));
    fdc_status_rate_asserts fdc_status_rate_asserts_inst (.MCLK_I(clk), .RESET_N_I(rst_n),
        .CE_I(ce), .addr(io_bus.addr), .wr(io_bus.wr), .rd(io_bus.rd), .wdata(io_bus.wdata),
        .rdata(io_bus.rdata), .SEEK_BUSY_I(seek), .CMD_BUSY_I(cmd), .EXEC_PHASE_I(exec),
        .NON_DMA_I(nondma), .REQUEST_I(req), .DIR_READ_I(dir), .CTRL_RESET_I(ctrl_rst),
        .FIFO_WR_O(fwr), .FIFO_RD_O(frd), .RATE_SEL_O(rate_sel), .LOW_POWER_O(lp),
        .SOFT_RESET_O(sres));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    // Entered just after a rising edge; holds the request until ack is sampled
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat_w <= d;
        do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 50);
        if (n >= 50) begin n_fail++; final_report(); end
        q = dat_r;
        cyc <= 1'b0; stb <= 1'b0;
        @(posedge clk);
    endtask : wb
    // One controller access, then poll the host status until idle
    task automatic io(input logic w, input logic [2:0] o, input logic [7:0] b,
                      output logic [31:0] s);
        int n;
        n = 0;
        wb(1'b1, HOST_OFS_REQ, {8'h00, b, 7'h00, w, 5'h00, o}, s);
        if (o == OFS_DATA) chk(busy, 1'b1, "busy");
        do begin wb(1'b0, HOST_OFS_STAT, 32'h0, s); n++; end while (s[0] !== 1'b0 && n < 20);
        if (n >= 20) begin n_fail++; final_report(); end
    endtask : io
    function automatic rate_t exp_rate(input logic [1:0] d, input logic [1:0] k);
        if (k == 2'h3) return RATE_1M;
        if (k == 2'h0) return RATE_500K;
        if (k == 2'h2) return RATE_250K;
        return (d == 2'h1) ? RATE_500K : (d == 2'h2) ? RATE_2M : RATE_300K;
    endfunction : exp_rate
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk(rate_sel, 2'h2, "sel");
        chk(rate, RATE_250K, "rate");
        chk(dens, 1'b1, "dens");
        chk(lp, 1'b0, "lp");
    endtask : t_reset
    task automatic t_status();
        logic [31:0] s;
        seek <= 4'h5; cmd <= 1'b1; exec <= 1'b1; nondma <= 1'b1; req <= 1'b1; dir <= 1'b1;
        io(1'b0, 3'h4, 8'h00, s);
        chk(s[15:8], 8'hF5, "status a");
        seek <= 4'hA; exec <= 1'b0; dir <= 1'b0;
        io(1'b0, 3'h4, 8'h00, s);
        chk(s[15:8], 8'h9A, "status b");
        seek <= 4'h0; cmd <= 1'b0; req <= 1'b0; dir <= 1'b1;
        io(1'b0, 3'h4, 8'h00, s);
        chk(s[15:8], 8'h00, "status c");
    endtask : t_status
    task automatic t_rates();
        logic [31:0] s;
        for (int d = 0; d < 3; d++) begin
            for (int k = 0; k < 4; k++) begin
                drt <= d[1:0];
                io(1'b1, 3'h4, {6'h00, k[1:0]}, s);
                chk(rate, exp_rate(d[1:0], k[1:0]), "rate");
                chk(rate_sel, k[1:0], "sel");
                chk(pre_ps, (k == 3) ? DLY_41_PS : DLY_125_PS, "default delay");
                chk(dens, (k == 0 || k == 3), "dens");
            end
        end
        drt <= 2'h0;
        ident <= 1'b0;
        io(1'b1, 3'h7, 8'h03, s);
        chk(rate, RATE_1M, "ctrl rate");
        chk(dens, 1'b0, "dens ident");
        ident <= 1'b1;
        for (int c = 0; c < 8; c++) begin
            io(1'b1, 3'h4, {3'h0, c[2:0], 2'h2}, s);
            chk(pre_ps, DL[c], "delay");
        end
        chk(rate, RATE_250K, "rate after");
        ptrk <= 8'h14;
        io(1'b1, 3'h4, 8'h06, s);
        chk(pre_ps, DLY_0_PS, "below start");
        ptrk <= 8'h00;
    endtask : t_rates
    task automatic t_power();
        logic [31:0] s;
        io(1'b1, 3'h4, 8'h42, s);
        chk(lp, 1'b1, "lp on");
        io(1'b0, 3'h4, 8'h00, s);
        chk(lp, 1'b0, "lp off read");
        io(1'b1, 3'h4, 8'h43, s);
        // Clock enable low must hold low power through a soft reset
        ce <= 1'b0;
        ctrl_rst <= 1'b1;
        @(posedge clk);
        ctrl_rst <= 1'b0;
        @(posedge clk);
        chk(lp, 1'b1, "lp frozen");
        ce <= 1'b1;
        ctrl_rst <= 1'b1;
        @(posedge clk);
        ctrl_rst <= 1'b0;
        repeat (3) @(posedge clk);
        chk(lp, 1'b0, "lp off reset");
        chk(rate_sel, 2'h3, "sel kept");
        chk(dens, 1'b1, "dens kept");
        io(1'b1, 3'h4, 8'hC2, s);
        chk(lp, 1'b0, "soft wins");
    endtask : t_power
    task automatic t_data();
        logic [31:0] s;
        req <= 1'b1; dir <= 1'b0;
        io(1'b1, 3'h5, 8'h5A, s);
        chk(s[1], 1'b0, "accepted");
        chk(fifo_wdata, 8'h5A, "wdata");
        dir <= 1'b1; fifo_rd <= 8'hA5;
        io(1'b0, 3'h5, 8'h00, s);
        chk(s[15:0], 16'hA500, "read byte");
        io(1'b0, 3'h4, 8'h00, s);
        chk(s[15:8], 8'hC0, "status after");
        req <= 1'b0;
        io(1'b1, 3'h5, 8'h11, s);
        chk(s[1], 1'b1, "refused");
        chk(fifo_wdata, 8'h5A, "no write");
    endtask : t_data
    task automatic t_tape();
        logic [31:0] s;
        io(1'b1, 3'h3, 8'hFF, s);
        io(1'b0, 3'h3, 8'h00, s);
        chk(s[15:8], 8'h03, "tape normal");
        enh <= 1'b1; tcfg <= 8'hE4; boot <= 2'h2;
        io(1'b1, 3'h3, 8'hC1, s);
        for (int k = 0; k < 4; k++) begin
            last <= k[1:0];
            io(1'b0, 3'h3, 8'h00, s);
            chk(s[15:8], {2'h0, k[1:0], 4'h9}, "tape enh");
        end
    endtask : t_tape
    // Hardware reset in mid-run must restore rate and density
    task automatic t_hw_reset();
        logic [31:0] s;
        ident <= 1'b0;
        io(1'b1, 3'h4, 8'h1F, s);
        chk(rate, RATE_1M, "rate pre");
        chk(dens, 1'b0, "dens pre");
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        ident <= 1'b1;
    endtask : t_hw_reset
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_status();
        t_rates();
        t_power();
        t_data();
        t_tape();
        t_hw_reset();
        final_report();
    end
endmodule : floppy_status_rate_regs_test
`default_nettype wire
